/* hdl/state_configurable_event_timer.sv */
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module state_configurable_event_timer (
  input wire logic clock, // 100 MHz system clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [7:0] addr, // Register word address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  input wire logic [3:0] ev_in, // Asynchronous event inputs
  input wire logic [3:0] gpt_match, // General timer match outputs
  output logic [3:0] ev_out, // Timer outputs
  output logic [3:0] adc_trig, // Converter trigger sources
  output logic ev_irq, // Interrupt request level
  output logic ev_dma // DMA request pulse
);

  typedef struct packed {
    logic [3:0] in_s1;
    logic [3:0] in_s2;
    logic [3:0] in_s3;
    logic [7:0] cfg;
    logic halt_l;
    logic stop_l;
    logic halt_h;
    logic stop_h;
    logic down_l;
    logic down_h;
    logic [15:0] cnt_l;
    logic [15:0] cnt_h;
    logic [2:0] state;
    logic [3:0] outs;
    logic [3:0] out_prev;
    logic [4:0] regmode;
    logic [5:0] flag;
    logic [5:0] irqen;
    logic [5:0] dmaen;
    logic [4:0][31:0] mr;
    logic [4:0][5:0] capctl;
    logic [5:0][7:0] evst;
    logic [5:0][17:0] evctl;
    logic [5:0][12:0] evact;
    logic [5:0] held;
    logic [31:0] rdata;
    logic irq;
    logic dma;
    logic [3:0] trig;
  } timer_s;

  timer_s s_q;
  timer_s s_d;

  logic unify;
  logic [2:0] clksel;
  logic [1:0] clk_idx;
  logic tick;
  logic [31:0] cnt32;
  logic [4:0] m_32;
  logic [4:0] m_l;
  logic [4:0] m_h;
  logic [5:0] fire;
  logic [5:0] mraw;
  logic [5:0] ioraw;
  logic [5:0] hsel;
  logic lim_l, lim_h, hlt_l, hlt_h, sta_l, sta_h, stp_l, stp_h, rev_l, rev_h;
  logic [3:0] oset;
  logic [3:0] oclr;
  logic ld_state;
  logic [2:0] nxt_state;
  logic [32:0] res_l;
  logic [32:0] res_h;
  logic [2:0] widx;
  logic wr_match, wr_capctl, wr_evst, wr_evctl, wr_evact;
  logic rd_match, rd_capctl, rd_evst, rd_evctl, rd_evact;

  // One count step: returns direction and value
  function automatic logic [32:0] step(input logic [31:0] v, input logic down, input logic lim,
                                       input logic bidir, input logic rev);
    logic d;
    logic [31:0] r;
    d = down ^ rev;
    r = v;
    if (!bidir) begin
      d = 1'b0;
      r = lim ? 32'h0 : v + 32'h1;
    end else if (d) begin
      if (v == 32'h0) begin
        d = 1'b0;
        r = v + 32'h1;
      end else begin
        r = v - 32'h1;
      end
    end else if (lim && v != 32'h0) begin
      d = 1'b1;
      r = v - 32'h1;
    end else begin
      r = v + 32'h1;
    end
    return {d, r};
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Two-stage sync, third stage only for edge history
    s_d.in_s1 = ev_in;
    s_d.in_s2 = s_q.in_s1;
    s_d.in_s3 = s_q.in_s2;
    s_d.out_prev = s_q.outs;

    // Counter clock: system clock, rising edge of a synced input, or none
    unify = s_q.cfg[evt_timer_pkg::CFG_UNIFY];
    clksel = s_q.cfg[evt_timer_pkg::CFG_CLKSEL +: 3];
    clk_idx = clksel[1:0] - 2'h1;
    if (clksel == 3'h0) begin
      tick = 1'b1;
    end else if (clksel <= 3'h4) begin
      tick = s_q.in_s2[clk_idx] & ~s_q.in_s3[clk_idx];
    end else begin
      tick = 1'b0;
    end

    // Match compare, only registers in match mode; gated by tick so a slow count fires once
    cnt32 = {s_q.cnt_h, s_q.cnt_l};
    for (int i = 0; i < evt_timer_pkg::NUM_MATCH; i++) begin
      m_32[i] = tick & ~s_q.regmode[i] & (cnt32 == s_q.mr[i]);
      m_l[i] = tick & ~s_q.regmode[i] & (s_q.cnt_l == s_q.mr[i][15:0]);
      m_h[i] = tick & ~s_q.regmode[i] & (s_q.cnt_h == s_q.mr[i][31:16]);
    end

    lim_l = 1'b0;
    lim_h = 1'b0;
    hlt_l = 1'b0;
    hlt_h = 1'b0;
    sta_l = 1'b0;
    sta_h = 1'b0;
    stp_l = 1'b0;
    stp_h = 1'b0;
    rev_l = 1'b0;
    rev_h = 1'b0;
    oset = 4'h0;
    oclr = 4'h0;
    ld_state = 1'b0;
    nxt_state = s_q.state;

    // Event evaluation; higher index wins the next-state choice
    for (int e = 0; e < evt_timer_pkg::NUM_EVENT; e++) begin
      logic [2:0] msel;
      logic [2:0] iosel;
      logic now_v, prev_v, mterm, cond, dir, dirok, halted;
      msel = s_q.evctl[e][evt_timer_pkg::EVC_MSEL +: 3];
      iosel = s_q.evctl[e][evt_timer_pkg::EVC_IOSEL +: 3];
      hsel[e] = s_q.evctl[e][evt_timer_pkg::EVC_HSEL] & ~unify;
      if (msel > 3'h4) begin
        mraw[e] = 1'b0;
      end else if (unify) begin
        mraw[e] = m_32[msel];
      end else begin
        mraw[e] = hsel[e] ? m_h[msel] : m_l[msel];
      end
      now_v = iosel[2] ? s_q.outs[iosel[1:0]] : s_q.in_s2[iosel[1:0]];
      prev_v = iosel[2] ? s_q.out_prev[iosel[1:0]] : s_q.in_s3[iosel[1:0]];
      unique case (s_q.evctl[e][evt_timer_pkg::EVC_IOCOND +: 2])
        evt_timer_pkg::IO_LOW: ioraw[e] = ~now_v;
        evt_timer_pkg::IO_RISE: ioraw[e] = now_v & ~prev_v;
        evt_timer_pkg::IO_FALL: ioraw[e] = ~now_v & prev_v;
        evt_timer_pkg::IO_HIGH: ioraw[e] = now_v;
      endcase
      // Held match stands in for a match that came earlier
      mterm = mraw[e] | s_q.held[e];
      unique case (s_q.evctl[e][evt_timer_pkg::EVC_COMB +: 2])
        evt_timer_pkg::CMB_OR: cond = mterm | ioraw[e];
        evt_timer_pkg::CMB_MATCH: cond = mterm;
        evt_timer_pkg::CMB_IO: cond = ioraw[e];
        evt_timer_pkg::CMB_AND: cond = mterm & ioraw[e];
      endcase
      dir = hsel[e] ? s_q.down_h : s_q.down_l;
      unique case (s_q.evctl[e][evt_timer_pkg::EVC_DIRQ +: 2])
        evt_timer_pkg::DIR_UP: dirok = ~dir;
        evt_timer_pkg::DIR_DOWN: dirok = dir;
        default: dirok = 1'b1;
      endcase
      // A halted counter takes no events; stop still lets a start event through
      halted = hsel[e] ? s_q.halt_h : s_q.halt_l;
      fire[e] = cond & dirok & ~halted & s_q.evst[e][s_q.state];
      s_d.held[e] = s_q.evctl[e][evt_timer_pkg::EVC_HOLD] & ~fire[e] & (s_q.held[e] | mraw[e]);

      // Counter actions routed to the selected half
      if (fire[e]) begin
        if (hsel[e]) begin
          lim_h = lim_h | s_q.evact[e][evt_timer_pkg::EVA_LIMIT];
          hlt_h = hlt_h | s_q.evact[e][evt_timer_pkg::EVA_HALT];
          sta_h = sta_h | s_q.evact[e][evt_timer_pkg::EVA_START];
          stp_h = stp_h | s_q.evact[e][evt_timer_pkg::EVA_STOP];
          rev_h = rev_h | s_q.evact[e][evt_timer_pkg::EVA_REV];
        end else begin
          lim_l = lim_l | s_q.evact[e][evt_timer_pkg::EVA_LIMIT];
          hlt_l = hlt_l | s_q.evact[e][evt_timer_pkg::EVA_HALT];
          sta_l = sta_l | s_q.evact[e][evt_timer_pkg::EVA_START];
          stp_l = stp_l | s_q.evact[e][evt_timer_pkg::EVA_STOP];
          rev_l = rev_l | s_q.evact[e][evt_timer_pkg::EVA_REV];
        end
        oset = oset | s_q.evact[e][evt_timer_pkg::EVA_SET +: 4];
        oclr = oclr | s_q.evact[e][evt_timer_pkg::EVA_CLR +: 4];
        if (s_q.evctl[e][evt_timer_pkg::EVC_LOAD]) begin
          ld_state = 1'b1;
          nxt_state = s_q.evctl[e][evt_timer_pkg::EVC_NEXT +: 3];
        end
      end
    end

    // Match 0 as automatic limit
    lim_l = lim_l | (s_q.cfg[evt_timer_pkg::CFG_AUTOLIM_L] & (unify ? m_32[0] : m_l[0]));
    lim_h = lim_h | (s_q.cfg[evt_timer_pkg::CFG_AUTOLIM_H] & m_h[0]);

    // Counting; in unified mode the low half's control governs all 32 bits
    res_l = unify ? step(cnt32, s_q.down_l, lim_l, s_q.cfg[evt_timer_pkg::CFG_BIDIR_L], rev_l)
                  : step({16'h0, s_q.cnt_l}, s_q.down_l, lim_l, s_q.cfg[evt_timer_pkg::CFG_BIDIR_L], rev_l);
    res_h = step({16'h0, s_q.cnt_h}, s_q.down_h, lim_h, s_q.cfg[evt_timer_pkg::CFG_BIDIR_H], rev_h);
    if (tick && !s_q.halt_l && !s_q.stop_l) begin
      s_d.cnt_l = res_l[15:0];
      s_d.down_l = res_l[32];
      if (unify) begin
        s_d.cnt_h = res_l[31:16];
      end
    end
    if (!unify && tick && !s_q.halt_h && !s_q.stop_h) begin
      s_d.cnt_h = res_h[15:0];
      s_d.down_h = res_h[32];
    end
    s_d.halt_l = s_q.halt_l | hlt_l;
    s_d.halt_h = s_q.halt_h | hlt_h;
    s_d.stop_l = (s_q.stop_l & ~sta_l) | stp_l;
    s_d.stop_h = (s_q.stop_h & ~sta_h) | stp_h;

    // State moves only on events or a software write, never on wrap or limit
    if (ld_state) begin
      s_d.state = nxt_state;
    end

    // Set and clear together toggles; set at period and clear at duty gives PWM
    for (int o = 0; o < evt_timer_pkg::NUM_IO; o++) begin
      if (oset[o] && oclr[o]) begin
        s_d.outs[o] = ~s_q.outs[o];
      end else if (oset[o]) begin
        s_d.outs[o] = 1'b1;
      end else if (oclr[o]) begin
        s_d.outs[o] = 1'b0;
      end
    end

    // Capture of the whole count into capture-mode registers
    for (int i = 0; i < evt_timer_pkg::NUM_MATCH; i++) begin
      if (s_q.regmode[i] && (fire & s_q.capctl[i]) != 6'h0) begin
        s_d.mr[i] = cnt32;
      end
    end

    // Requests: sticky flag, level interrupt, one-cycle DMA pulse
    s_d.irq = |(s_q.flag & s_q.irqen);
    s_d.dma = |(fire & s_q.dmaen);
    s_d.trig = s_q.outs | gpt_match;

    // Register writes; software wins over events except on flags
    widx = addr[2:0];
    wr_match = wr && addr[7:3] == evt_timer_pkg::B_MATCH && widx < 3'h5;
    wr_capctl = wr && addr[7:3] == evt_timer_pkg::B_CAPCTL && widx < 3'h5;
    wr_evst = wr && addr[7:3] == evt_timer_pkg::B_EVSTATE && widx < 3'h6;
    wr_evctl = wr && addr[7:3] == evt_timer_pkg::B_EVCTL && widx < 3'h6;
    wr_evact = wr && addr[7:3] == evt_timer_pkg::B_EVACT && widx < 3'h6;
    s_d.flag = s_q.flag | fire;
    if (wr) begin
      unique case (addr)
        evt_timer_pkg::A_CONFIG: s_d.cfg = wdata[7:0];
        evt_timer_pkg::A_CTRL: begin
          s_d.halt_l = wdata[evt_timer_pkg::CTL_HALT_L];
          s_d.stop_l = wdata[evt_timer_pkg::CTL_STOP_L];
          s_d.halt_h = wdata[evt_timer_pkg::CTL_HALT_H];
          s_d.stop_h = wdata[evt_timer_pkg::CTL_STOP_H];
          s_d.down_l = wdata[evt_timer_pkg::CTL_DOWN_L];
          s_d.down_h = wdata[evt_timer_pkg::CTL_DOWN_H];
        end
        evt_timer_pkg::A_COUNT: begin
          s_d.cnt_l = wdata[15:0];
          s_d.cnt_h = wdata[31:16];
        end
        evt_timer_pkg::A_STATE: s_d.state = wdata[2:0];
        evt_timer_pkg::A_OUTPUT: s_d.outs = wdata[3:0];
        evt_timer_pkg::A_REGMODE: s_d.regmode = wdata[4:0];
        // Write one to clear; a new event in the same cycle keeps its flag
        evt_timer_pkg::A_FLAG: s_d.flag = (s_q.flag & ~wdata[5:0]) | fire;
        evt_timer_pkg::A_IRQEN: s_d.irqen = wdata[5:0];
        evt_timer_pkg::A_DMAEN: s_d.dmaen = wdata[5:0];
        default: ;
      endcase
    end
    if (wr_match) begin
      s_d.mr[widx] = wdata;
    end
    if (wr_capctl) begin
      s_d.capctl[widx] = wdata[5:0];
    end
    if (wr_evst) begin
      s_d.evst[widx] = wdata[7:0];
    end
    if (wr_evctl) begin
      s_d.evctl[widx] = wdata[17:0];
    end
    if (wr_evact) begin
      s_d.evact[widx] = wdata[12:0];
    end

    // Register reads; unmapped words read as zero
    rd_match = addr[7:3] == evt_timer_pkg::B_MATCH && widx < 3'h5;
    rd_capctl = addr[7:3] == evt_timer_pkg::B_CAPCTL && widx < 3'h5;
    rd_evst = addr[7:3] == evt_timer_pkg::B_EVSTATE && widx < 3'h6;
    rd_evctl = addr[7:3] == evt_timer_pkg::B_EVCTL && widx < 3'h6;
    rd_evact = addr[7:3] == evt_timer_pkg::B_EVACT && widx < 3'h6;
    s_d.rdata = 32'h0;
    if (rd) begin
      if (rd_match) begin
        s_d.rdata = s_q.mr[widx];
      end else if (rd_capctl) begin
        s_d.rdata = {26'h0, s_q.capctl[widx]};
      end else if (rd_evst) begin
        s_d.rdata = {24'h0, s_q.evst[widx]};
      end else if (rd_evctl) begin
        s_d.rdata = {14'h0, s_q.evctl[widx]};
      end else if (rd_evact) begin
        s_d.rdata = {19'h0, s_q.evact[widx]};
      end else begin
        unique case (addr)
          evt_timer_pkg::A_CONFIG: s_d.rdata = {24'h0, s_q.cfg};
          evt_timer_pkg::A_CTRL: s_d.rdata = {26'h0, s_q.down_h, s_q.down_l, s_q.stop_h, s_q.halt_h,
                                              s_q.stop_l, s_q.halt_l};
          evt_timer_pkg::A_COUNT: s_d.rdata = cnt32;
          evt_timer_pkg::A_STATE: s_d.rdata = {29'h0, s_q.state};
          evt_timer_pkg::A_IOSTAT: s_d.rdata = {24'h0, s_q.outs, s_q.in_s2};
          evt_timer_pkg::A_OUTPUT: s_d.rdata = {28'h0, s_q.outs};
          evt_timer_pkg::A_REGMODE: s_d.rdata = {27'h0, s_q.regmode};
          evt_timer_pkg::A_FLAG: s_d.rdata = {26'h0, s_q.flag};
          evt_timer_pkg::A_IRQEN: s_d.rdata = {26'h0, s_q.irqen};
          evt_timer_pkg::A_DMAEN: s_d.rdata = {26'h0, s_q.dmaen};
          default: s_d.rdata = 32'h0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.halt_l <= evt_timer_pkg::RST_HALT;
      s_q.halt_h <= evt_timer_pkg::RST_HALT;
      s_q.state <= evt_timer_pkg::RST_STATE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign rdata = s_q.rdata;
  assign ev_out = s_q.outs;
  assign adc_trig = s_q.trig;
  assign ev_irq = s_q.irq;
  assign ev_dma = s_q.dma;
endmodule

/* hdl/evt_timer_pkg.sv */
package evt_timer_pkg;
  localparam int NUM_MATCH = 5;
  localparam int NUM_EVENT = 6;
  localparam int NUM_IO = 4;
  localparam int NUM_STATE = 8;

  // Word addresses of the register port
  localparam logic [7:0] A_CONFIG = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h01;
  localparam logic [7:0] A_COUNT = 8'h02;
  localparam logic [7:0] A_STATE = 8'h03;
  localparam logic [7:0] A_IOSTAT = 8'h04;
  localparam logic [7:0] A_OUTPUT = 8'h05;
  localparam logic [7:0] A_REGMODE = 8'h06;
  localparam logic [7:0] A_FLAG = 8'h07;
  localparam logic [7:0] A_IRQEN = 8'h08;
  localparam logic [7:0] A_DMAEN = 8'h09;
  localparam logic [4:0] B_MATCH = 5'h02;
  localparam logic [4:0] B_CAPCTL = 5'h03;
  localparam logic [4:0] B_EVSTATE = 5'h04;
  localparam logic [4:0] B_EVCTL = 5'h05;
  localparam logic [4:0] B_EVACT = 5'h06;

  // Configuration fields
  localparam int CFG_UNIFY = 0;
  localparam int CFG_CLKSEL = 1;
  localparam int CFG_BIDIR_L = 4;
  localparam int CFG_BIDIR_H = 5;
  localparam int CFG_AUTOLIM_L = 6;
  localparam int CFG_AUTOLIM_H = 7;
  // Control fields
  localparam int CTL_HALT_L = 0;
  localparam int CTL_STOP_L = 1;
  localparam int CTL_HALT_H = 2;
  localparam int CTL_STOP_H = 3;
  localparam int CTL_DOWN_L = 4;
  localparam int CTL_DOWN_H = 5;
  // Event control fields
  localparam int EVC_MSEL = 0;
  localparam int EVC_HSEL = 3;
  localparam int EVC_IOSEL = 6 - 2;
  localparam int EVC_IOCOND = 7;
  localparam int EVC_COMB = 9;
  localparam int EVC_DIRQ = 11;
  localparam int EVC_HOLD = 13;
  localparam int EVC_NEXT = 14;
  localparam int EVC_LOAD = 17;
  // Event action fields
  localparam int EVA_LIMIT = 0;
  localparam int EVA_HALT = 1;
  localparam int EVA_START = 2;
  localparam int EVA_STOP = 3;
  localparam int EVA_REV = 4;
  localparam int EVA_SET = 5;
  localparam int EVA_CLR = 9;

  // Encodings
  localparam logic [1:0] IO_LOW = 2'h0;
  localparam logic [1:0] IO_RISE = 2'h1;
  localparam logic [1:0] IO_FALL = 2'h2;
  localparam logic [1:0] IO_HIGH = 2'h3;
  localparam logic [1:0] CMB_OR = 2'h0;
  localparam logic [1:0] CMB_MATCH = 2'h1;
  localparam logic [1:0] CMB_IO = 2'h2;
  localparam logic [1:0] CMB_AND = 2'h3;
  localparam logic [1:0] DIR_ANY = 2'h0;
  localparam logic [1:0] DIR_UP = 2'h1;
  localparam logic [1:0] DIR_DOWN = 2'h2;

  // Reset values
  localparam logic RST_HALT = 1'b1;
  localparam logic [2:0] RST_STATE = 3'h0;
endpackage

/* tb/evt_timer_asserts.sv */
`timescale 1ns/1ps
module evt_timer_asserts (
  input wire logic clock, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic [7:0] addr, // Register address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [31:0] rdata, // Read data
  input wire logic [3:0] ev_in, // Event pins
  input wire logic [3:0] gpt_match, // General timer matches
  input wire logic [3:0] ev_out, // Timer outputs
  input wire logic [3:0] adc_trig, // Converter triggers
  input wire logic ev_irq, // Interrupt
  input wire logic ev_dma // DMA request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  trig_or_a: assert property ($past(rstn) && ce && $past(ce) |-> adc_trig == $past(ev_out | gpt_match))
    else $error("trigger not prior output or match");
  reset_out_a: assert property (disable iff (1'b0) !rstn |=> ev_out == 4'h0 && !ev_irq && !ev_dma)
    else $error("outputs not low after reset");
  rdata_idle_a: assert property ($past(rstn) && $past(ce) && !$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  out_write_a: assert property (wr && ce && addr == evt_timer_pkg::A_OUTPUT |=> ev_out == $past(wdata[3:0]))
    else $error("output write lost");
  iostat_out_a: assert property (rd && ce && addr == evt_timer_pkg::A_IOSTAT |=> rdata[7:4] == $past(ev_out))
    else $error("status misreports outputs");
  // Pins steady for three cycles, so the synchronised copy must agree
  iostat_in_a: assert property (rd && ce && addr == evt_timer_pkg::A_IOSTAT && $stable(ev_in)
    && ev_in == $past(ev_in, 2) |=> rdata[3:0] == $past(ev_in))
    else $error("status misreports inputs");
  irq_off_a: assert property ((wr && ce && addr == evt_timer_pkg::A_IRQEN && wdata == 32'h0)
    ##1 (ce && !(wr && addr == evt_timer_pkg::A_IRQEN)) |=> !ev_irq)
    else $error("interrupt stays with enables clear");
  unmapped_a: assert property (rd && ce && addr inside {8'h15, 8'h1d, 8'h26, 8'h2e, 8'h36, 8'hff}
    |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  dma_c: cover property (ev_dma);
  irq_c: cover property (ev_irq ##1 !ev_irq);
  stat_c: cover property (rd && addr == evt_timer_pkg::A_IOSTAT);
endmodule
bind state_configurable_event_timer evt_timer_asserts evt_timer_asserts_inst (.clock(clock), .rstn(rstn),
  .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ev_in(ev_in), .gpt_match(gpt_match),
  .ev_out(ev_out), .adc_trig(adc_trig), .ev_irq(ev_irq), .ev_dma(ev_dma));

/* tb/evt_pins_model.sv */
`timescale 1ns/1ps
module evt_pins_model (
  input wire logic clock, // Clock
  input wire logic [3:0] pin_lvl, // Level asked of the pins
  output logic [3:0] ev_in, // Pins into the timer
  output logic [3:0] gpt_match // General timer match lines
);
  int seed = 42;
  // Pins follow the bench; matches wander so the trigger OR is exercised
  initial begin
    ev_in = 4'h0;
    gpt_match = 4'h0;
  end
  always @(posedge clock) begin
    ev_in <= pin_lvl;
    gpt_match <= 4'($random(seed));
  end
endmodule

/* tb/state_configurable_event_timer_test.sv */
`timescale 1ns/1ps
module state_configurable_event_timer_test;
  logic clock, rstn, ce, wr, rd, ev_irq, ev_dma;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] ev_in, gpt_match, ev_out, adc_trig, pin_lvl;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 42;
  int dma_seen = 0;
  int n, e, h1, h2;
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  state_configurable_event_timer state_configurable_event_timer_inst (.clock(clock), .rstn(rstn), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ev_in(ev_in), .gpt_match(gpt_match),
    .ev_out(ev_out), .adc_trig(adc_trig), .ev_irq(ev_irq), .ev_dma(ev_dma));
  evt_pins_model evt_pins_model_inst (.clock(clock), .pin_lvl(pin_lvl), .ev_in(ev_in), .gpt_match(gpt_match));
  always @(posedge clock) if (ev_dma === 1'b1) dma_seen <= dma_seen + 1;
  // ----------------------------------------
  // Bus tasks and reference model
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data is taken only in the slot after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a, d);
    chk(d, exp);
  endtask
  // Rising edges on pin 0, spaced well past the synchroniser
  task automatic pulse(input int k);
    repeat (k) begin
      pin_lvl[0] <= 1'b1;
      repeat (4) @(posedge clock);
      pin_lvl[0] <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  function automatic int cnt_model(int k, int lim, int bi);
    int c;
    int up;
    c = 0;
    up = 1;
    repeat (k) begin
      if (bi == 1 && c == lim) up = 0;
      if (bi == 0 && c == lim) c = -1;
      c = (up == 1) ? c + 1 : c - 1;
    end
    return c;
  endfunction
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog well beyond the roughly 800 cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    print_verdict();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {rstn, wr, rd, addr, wdata, pin_lvl} = '0;
    ce = 1'b1;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    rdc(evt_timer_pkg::A_CTRL, 32'h5);
    rdc(evt_timer_pkg::A_STATE, 32'h0);
    for (n = 0; n < 5; n++) begin
      d = $random(seed);
      wr_reg(8'h10 + 8'(n), d);
      rdc(8'h10 + 8'(n), d);
    end
    wr_reg(8'hff, 32'hffffffff);
    rdc(8'hff, 32'h0);
    rdc(8'h15, 32'h0);
    // Edge-clocked count against match 0 as limit, up then bidirectional
    for (n = 0; n < 2; n++) begin
      wr_reg(evt_timer_pkg::A_CTRL, 32'h5);
      wr_reg(evt_timer_pkg::A_COUNT, 32'h0);
      wr_reg(8'h10, 32'h4);
      wr_reg(evt_timer_pkg::A_CONFIG, 32'h42 | (n << 4));
      wr_reg(evt_timer_pkg::A_CTRL, 32'h4);
      pulse(6);
      rdc(evt_timer_pkg::A_COUNT, cnt_model(6, 4, n));
    end
    rdc(evt_timer_pkg::A_CTRL, 32'h14);
    // Carry across bit 16 only when unified; short run keeps the range tight
    for (n = 0; n < 2; n++) begin
      wr_reg(evt_timer_pkg::A_CTRL, 32'h5);
      wr_reg(evt_timer_pkg::A_CONFIG, n);
      wr_reg(evt_timer_pkg::A_COUNT, 32'hfffe);
      wr_reg(evt_timer_pkg::A_CTRL, 32'h4);
      ce <= 1'b0; // Frozen cycles must not count, else the window is missed
      repeat (40) @(posedge clock);
      ce <= 1'b1;
      repeat (10) @(posedge clock);
      wr_reg(evt_timer_pkg::A_CTRL, 32'h5);
      rd_reg(evt_timer_pkg::A_COUNT, d);
      chk(32'((n == 1) ? (d >= 32'h10000 && d < 32'h10020) : (d < 32'h20)), 32'h1);
    end
    // Pin event: masked first, then enabled with state load, capture, irq, dma
    wr_reg(evt_timer_pkg::A_CONFIG, 32'h0a);
    wr_reg(evt_timer_pkg::A_CTRL, 32'h4);
    wr_reg(evt_timer_pkg::A_COUNT, 32'h1234);
    wr_reg(evt_timer_pkg::A_REGMODE, 32'h2);
    wr_reg(8'h19, 32'h1);
    wr_reg(8'h30, 32'h20);
    wr_reg(8'h28, 32'h7 | (32'h1 << 7) | (32'h2 << 9) | (32'h3 << 14) | (32'h1 << 17));
    wr_reg(8'h20, 32'h2);
    wr_reg(evt_timer_pkg::A_IRQEN, 32'h1);
    wr_reg(evt_timer_pkg::A_DMAEN, 32'h1);
    pulse(1);
    rdc(evt_timer_pkg::A_STATE, 32'h0);
    chk(32'(ev_out), 32'h0);
    wr_reg(8'h20, 32'h1);
    e = dma_seen;
    pulse(1);
    chk(dma_seen - e, 1);
    rdc(evt_timer_pkg::A_STATE, 32'h3);
    chk(32'(ev_out), 32'h1);
    chk(32'(ev_irq), 32'h1);
    rdc(8'h11, 32'h1234);
    wr_reg(evt_timer_pkg::A_OUTPUT, 32'h0);
    pulse(1);
    chk(32'(ev_out), 32'h0);
    wr_reg(evt_timer_pkg::A_FLAG, 32'h1);
    repeat (3) @(posedge clock);
    chk(32'(ev_irq), 32'h0);
    wr_reg(evt_timer_pkg::A_STATE, 32'h0);
    // Every pin condition, at both steady levels and across the change
    for (n = 0; n < 8; n++) begin
      pin_lvl[0] <= n[0];
      repeat (6) @(posedge clock);
      wr_reg(8'h28, 32'h7 | (32'(n >> 1) << 7) | (32'h2 << 9));
      wr_reg(evt_timer_pkg::A_OUTPUT, 32'h0);
      repeat (6) @(posedge clock);
      e = ((n >> 1) == 0 && !n[0]) || ((n >> 1) == 3 && n[0]);
      chk(32'(ev_out[0]), e);
      rd_reg(evt_timer_pkg::A_IOSTAT, d);
      chk(32'(d[0]), n[0]);
      pin_lvl[0] <= !n[0];
      repeat (6) @(posedge clock);
      e = (n >> 1) == 0 || (n >> 1) == 3 || ((n >> 1) == 1 && !n[0]) || ((n >> 1) == 2 && n[0]);
      chk(32'(ev_out[0]), e);
    end
    wr_reg(evt_timer_pkg::A_IRQEN, 32'h0);
    repeat (3) @(posedge clock);
    chk(32'(ev_irq), 32'h0);
    // Trigger lags a known output word OR the general match lines by one cycle
    wr_reg(8'h20, 32'h0);
    d = $random(seed);
    wr_reg(evt_timer_pkg::A_OUTPUT, d);
    for (n = 0; n < 8; n++) begin
      @(posedge clock);
      #1 e = int'(gpt_match);
      @(posedge clock);
      #1 chk(32'(adc_trig), (d & 32'hf) | 32'(e));
    end
    // PWM: match 0 period of 10, match 2 duty; set plus clear toggles output 2
    wr_reg(evt_timer_pkg::A_REGMODE, 32'h0);
    wr_reg(8'h10, 32'h9);
    wr_reg(8'h11, 32'h5);
    wr_reg(8'h12, 32'h3);
    wr_reg(8'h29, 32'h200);
    wr_reg(8'h31, 32'h8c0);
    wr_reg(8'h21, 32'hff);
    wr_reg(8'h2a, 32'h202);
    wr_reg(8'h32, 32'h400);
    wr_reg(8'h22, 32'hff);
    wr_reg(evt_timer_pkg::A_OUTPUT, 32'h0);
    wr_reg(evt_timer_pkg::A_COUNT, 32'h0);
    wr_reg(evt_timer_pkg::A_CONFIG, 32'h40);
    wr_reg(evt_timer_pkg::A_CTRL, 32'h4);
    repeat (12) @(posedge clock);
    h1 = 0;
    h2 = 0;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      h1 += ev_out[1];
      h2 += ev_out[2];
    end
    chk(h1, 100 * (3 + 1) / (9 + 1));
    chk(h2, 50);
    // Match 2 held, then moved out of reach, so only the held copy meets the pin edge
    wr_reg(8'h2c, 32'h2682);
    wr_reg(8'h34, 32'h100);
    wr_reg(8'h24, 32'hff);
    repeat (12) @(posedge clock);
    wr_reg(8'h12, 32'h20);
    repeat (12) @(posedge clock);
    chk(32'(ev_out[3]), 32'h0);
    pulse(1);
    chk(32'(ev_out[3]), 32'h1);
    // Match 1 halts the low counter one step past the match value
    wr_reg(8'h2b, 32'h201);
    wr_reg(8'h33, 32'h2);
    wr_reg(8'h23, 32'hff);
    repeat (20) @(posedge clock);
    rdc(evt_timer_pkg::A_COUNT, 32'h5 + 32'h1);
    rdc(evt_timer_pkg::A_CTRL, 32'h5);
    print_verdict();
  end
endmodule
